// [hw/cse_pkg.sv]
`default_nettype none
package cse_pkg;
    // ---------------------------------------------
    // Subframe geometry and sample format
    // ---------------------------------------------
    localparam int SUBFRAME_LEN = 40;
    localparam int SMP_IDX_W = 6;
    localparam int SMP_W = 16;
    localparam int NUM_BASIS = 7;

    // ---------------------------------------------
    // Gain output and gain quantizer
    // ---------------------------------------------
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 12;
    localparam int GQ_ENTRIES = 32;
    localparam int GQ_IDX_W = 5;
    localparam int GQ_ERR_W = 32;

    // ---------------------------------------------
    // Voicing modes
    // ---------------------------------------------
    localparam int MODE_W = 2;
    localparam logic [MODE_W-1:0] MODE_TWO_CB = 2'h0;

    typedef logic [MODE_W-1:0] cse_mode_t;

    // Reference and target samples for one index n
    typedef struct packed {
        logic signed [SMP_W-1:0] ref_smp;
        logic signed [SMP_W-1:0] tgt_smp;
    } cse_aux_t;

    // One codebook search answer
    typedef struct packed {
        logic second_cb;
        cse_mode_t mode;
        logic [GAIN_W-1:0] gain;
    } cse_res_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_LOAD = 7'h02,
        ST_PREP = 7'h04,
        ST_INIT = 7'h08,
        ST_SCAN = 7'h10,
        ST_DIV = 7'h20,
        ST_GQ = 7'h40
    } cse_state_t;
endpackage : cse_pkg
`default_nettype wire

// [hw/cse_engine.sv]
// How it works
// RL1: Nonzero mode starts only once the lag is known; one index comes out.
// RL2: Codebook has 2^M entries built from M signed basis vectors, no table.
// RL3: Bit m set gives basis m sign +1, clear gives -1.
// RL4: Filtered codevector uses the same signs on the filtered basis vectors.
// RL5: Mode 0 searches two codebooks in turn, giving a first then second index.
// RL6: Second mode 0 search scores assuming joint optimal gains with first vector.
// RL7: Nonzero mode: basis vectors are decorrelated against the prediction vector.
// RL8: Mode 0 decorrelates only the second codebook, against the first choice.
// RL9: Winner maximises squared correlation over decorrelated energy.
// RL10: Reported gain is correlation term over energy term of the winner.
// RL11: Precompute twice target correlation and four times pair cross-correlation.
// RL12: Energy is half signed off-diagonal pair sum plus quarter diagonal sum.
// RL13: Single-bit step adds signed correlation and signed pair values of bit v.
// RL14: Codewords are visited in binary Gray code order.
// RL15: Each step costs at most M multiply-accumulates.
// RL16: Only half the codebook is evaluated; complements score the same.
// RL17: Output winner if its correlation is positive, else its complement.
// RL18: Running best is replaced only by a strictly greater score.
// RL19: Comparison cross-multiplies squared correlations and energies, no divide.
// RL20: One gain quantizer per voicing mode; only the frame mode's one is searched.
// RL21: First excitation is prediction vector in modes 1-3, first codevector in 0.
// RL22: All vectors span one 40-sample subframe.
// RL23: Gain quantizer scores 32 entries and keeps the minimum error.
// RL24: Basis count M is a parameter and the index is M bits wide.
// RL25: Equal scores keep the earlier codeword in Gray order.
`default_nettype none
module cse_engine #(
    parameter int M = cse_pkg::NUM_BASIS,
    parameter int NS = cse_pkg::SUBFRAME_LEN
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Subframe control
    input wire logic i_start,
    input wire cse_pkg::cse_mode_t i_mode,
    input wire logic i_lag_valid,
    output logic o_busy,
    // Sample stream
    input wire logic i_smp_valid,
    output logic o_smp_ready,
    input wire logic signed [cse_pkg::SMP_W-1:0] i_basis [M],
    input wire cse_pkg::cse_aux_t i_aux,
    // Codebook answer
    output logic o_res_valid,
    output cse_pkg::cse_res_t o_res,
    output logic [M-1:0] o_idx,
    // Gain quantizer
    output cse_pkg::cse_mode_t o_gq_sel,
    output logic o_gq_first_cb,
    input wire logic i_gq_valid,
    output logic o_gq_ready,
    input wire logic signed [cse_pkg::GQ_ERR_W-1:0] i_gq_err,
    output logic o_gq_valid,
    output logic [cse_pkg::GQ_IDX_W-1:0] o_gq_idx
);
    import cse_pkg::*;

    // ---------------------------------------------
    // Widths
    // ---------------------------------------------
    localparam int VW = $clog2(M);
    localparam int RW = SMP_W + 4;
    localparam int AW = 2 * RW + SMP_IDX_W;
    localparam int TW = 2 * AW + 3;
    localparam int CW = TW + 8;
    localparam int GW = TW + 12;
    localparam int PW = 2 * CW + GW;
    localparam int DW = GW + GAIN_W + 1;
    localparam int BW = $clog2(GAIN_W + 1);
    localparam logic [M-2:0] K_LAST = '1;

    cse_state_t st_q;
    cse_mode_t mode_q;
    logic cb_q;
    logic [SMP_IDX_W-1:0] n_q;
    logic [M-1:0] cw1_q;
    logic signed [SMP_W-1:0] mem_q [NS][M];
    logic signed [AW-1:0] gam_q, bp_q;
    logic signed [AW-1:0] psi_q [M];
    logic signed [AW-1:0] pq_q [M];
    logic signed [AW-1:0] qq_q [M][M];
    logic signed [TW-1:0] gm;
    logic signed [TW-1:0] ps [M];
    logic signed [CW-1:0] r_q [M];
    logic signed [GW-1:0] d_q [M][M];
    logic signed [CW-1:0] c_q, best_c_q, c_n, init_c, c_abs;
    logic signed [GW-1:0] g_q, best_g_q, g_n, init_g;
    logic [M-1:0] cw_q, best_cw_q, cw_n, pick_cw;
    logic [M-2:0] k_q, k_n;
    logic [VW-1:0] v;
    logic better;
    logic [DW-1:0] rem_q, trial, num;
    logic [GAIN_W-1:0] quo_q, quo_n;
    logic [BW-1:0] bit_q;
    logic sat_q, ge, div_last;
    logic [GQ_IDX_W-1:0] gq_cnt_q, gq_best_idx_q;
    logic signed [GQ_ERR_W-1:0] gq_min_q;
    logic gq_fire, gq_lower, gq_last;
    logic fire, acc_clr, use_ref, start_ok, last_smp, two_pass;
    logic signed [RW-1:0] ref_s;

    default clocking cse_cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    function automatic logic signed [AW-1:0] mac(input logic signed [AW-1:0] acc,
        input logic signed [RW-1:0] a, input logic signed [RW-1:0] b, input logic clr);
        logic signed [AW-1:0] p;
        p = AW'(a) * AW'(b);
        return clr ? p : acc + p;
    endfunction : mac

    // Lowest set bit gives the Gray code flip position
    function automatic logic [VW-1:0] lsb_pos(input logic [M-2:0] k);
        lsb_pos = '0;
        for (int b = M - 2; b >= 0; b--) begin
            if (k[b]) lsb_pos = VW'(b);
        end
    endfunction : lsb_pos

    // ---------------------------------------------
    // Sequencing
    // ---------------------------------------------
    assign fire = (st_q == ST_LOAD) && i_smp_valid;
    assign last_smp = fire && (n_q == SMP_IDX_W'(NS - 1)); // RL22
    assign start_ok = i_start && ((i_mode == MODE_TWO_CB) || i_lag_valid); // RL1
    assign acc_clr = (n_q == '0);
    assign two_pass = (mode_q == MODE_TWO_CB) && !cb_q;
    assign use_ref = !two_pass; // RL7 RL8 RL6
    assign div_last = (st_q == ST_DIV) && (bit_q == '0);
    assign o_busy = (st_q != ST_IDLE);
    assign o_smp_ready = (st_q == ST_LOAD);

    // Main state machine; the two-codebook mode loops back for a second load
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            st_q <= ST_IDLE;
            mode_q <= '0;
            cb_q <= 1'h0;
            n_q <= '0;
            cw1_q <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: if (start_ok) begin
                    mode_q <= i_mode;
                    cb_q <= 1'h0;
                    n_q <= '0;
                    st_q <= ST_LOAD;
                end
                ST_LOAD: if (fire) begin
                    n_q <= last_smp ? '0 : n_q + 1'h1;
                    if (last_smp) st_q <= ST_PREP;
                end
                ST_PREP: st_q <= ST_INIT;
                ST_INIT: st_q <= ST_SCAN;
                ST_SCAN: if (k_n == K_LAST) st_q <= ST_DIV; // RL16
                ST_DIV: if (div_last) begin
                    if (two_pass) begin
                        cw1_q <= best_cw_q; // RL5
                        cb_q <= 1'h1;
                        st_q <= ST_LOAD;
                    end else begin
                        st_q <= ST_GQ;
                    end
                end
                ST_GQ: if (gq_last) st_q <= ST_IDLE;
                default: st_q <= ST_IDLE; // Illegal one-hot code
            endcase
        end
    end

    // First-codebook basis kept so its chosen codevector can be rebuilt later
    always_ff @(posedge i_core_clk) begin
        if (fire && two_pass) begin
            for (int m = 0; m < M; m++) begin
                mem_q[n_q][m] <= i_basis[m];
            end
        end
    end

    // Reference vector: prediction vector, or rebuilt first codevector
    always_comb begin
        ref_s = RW'(i_aux.ref_smp);
        if (mode_q == MODE_TWO_CB) begin
            ref_s = '0; // Empty on the first pass, so unwritten memory never reaches the sums
            for (int m = 0; m < M; m++) begin
                if (cb_q) ref_s = cw1_q[m] ? ref_s + RW'(mem_q[n_q][m]) : ref_s - RW'(mem_q[n_q][m]); // RL3 RL4 RL8
            end
        end
    end

    // ---------------------------------------------
    // Correlations and decorrelated precompute
    // ---------------------------------------------
    // Reference energy, with a unit stand-in when there is nothing to remove
    assign gm = TW'((use_ref && (gam_q != '0)) ? gam_q : AW'(1)); // RL7

    // Accumulate once per sample
    always_ff @(posedge i_core_clk) begin
        if (fire) begin
            gam_q <= mac(gam_q, ref_s, ref_s, acc_clr); // RL7
            bp_q <= mac(bp_q, ref_s, RW'(i_aux.tgt_smp), acc_clr);
        end
    end

    // Decorrelation is folded in algebraically, scaled by the reference
    // energy; that scale cancels in both score and gain, so no divider here
    for (genvar m = 0; m < M; m++) begin : g_basis
        assign ps[m] = use_ref ? TW'(psi_q[m]) : '0;

        // Per-basis accumulators; lower triangle tied off
        always_ff @(posedge i_core_clk) begin
            if (fire) begin
                psi_q[m] <= mac(psi_q[m], ref_s, RW'(i_basis[m]), acc_clr); // RL7
                pq_q[m] <= mac(pq_q[m], RW'(i_basis[m]), RW'(i_aux.tgt_smp), acc_clr);
                for (int j = 0; j < M; j++) begin
                    qq_q[m][j] <= (j >= m) ? mac(qq_q[m][j], RW'(i_basis[m]), RW'(i_basis[j]), acc_clr) : '0;
                end
            end
        end

        // Doubled correlation and quadrupled pair terms
        always_ff @(posedge i_core_clk) begin
            if (st_q == ST_PREP) begin
                r_q[m] <= CW'(gm * TW'(pq_q[m]) - ps[m] * TW'(bp_q)) <<< 1; // RL11 RL7
                for (int j = 0; j < M; j++) begin
                    d_q[m][j] <= GW'(gm * TW'(qq_q[(j >= m) ? m : j][(j >= m) ? j : m]) - ps[m] * ps[j]) <<< 2; // RL11
                end
            end
        end
    end

    // ---------------------------------------------
    // Gray code scan
    // ---------------------------------------------
    // Start at codeword 0: every sign is -1; held as 2C and 4G
    always_comb begin
        init_c = '0;
        init_g = '0;
        for (int m = 0; m < M; m++) begin
            init_c = init_c - r_q[m]; // RL11
            init_g = init_g + d_q[m][m]; // RL12
            for (int j = m + 1; j < M; j++) begin
                init_g = init_g + (d_q[m][j] <<< 1); // RL12
            end
        end
    end

    // One flipped bit per step: one term for C, M-1 for G
    always_comb begin
        k_n = k_q + 1'h1;
        v = lsb_pos(k_n);
        cw_n = cw_q ^ (M'(1) << v); // RL14 RL2
        c_n = cw_n[v] ? c_q + (r_q[v] <<< 1) : c_q - (r_q[v] <<< 1); // RL13
        g_n = g_q;
        for (int j = 0; j < M; j++) begin
            if (VW'(j) != v) begin
                g_n = (cw_n[j] == cw_n[v]) ? g_n + (d_q[v][j] <<< 2) : g_n - (d_q[v][j] <<< 2); // RL13 RL15
            end
        end
        // Cross-multiplied score test avoids a divide per candidate
        better = PW'(c_n) * PW'(c_n) * PW'(best_g_q) > PW'(best_c_q) * PW'(best_c_q) * PW'(g_n); // RL9 RL19
    end

    // Running terms and running best
    always_ff @(posedge i_core_clk) begin
        if (st_q == ST_INIT) begin
            c_q <= init_c;
            g_q <= init_g;
            best_c_q <= init_c;
            best_g_q <= init_g;
            cw_q <= '0;
            best_cw_q <= '0;
            k_q <= '0;
        end else if (st_q == ST_SCAN) begin
            c_q <= c_n;
            g_q <= g_n;
            cw_q <= cw_n;
            k_q <= k_n;
            if (better) begin // RL18 RL25
                best_c_q <= c_n;
                best_g_q <= g_n;
                best_cw_q <= cw_n;
            end
        end
    end

    // Sign choice keeps the gain positive
    assign pick_cw = (best_c_q > 0) ? best_cw_q : ~best_cw_q; // RL17 RL24

    // ---------------------------------------------
    // Gain divide: gain = 2 * (2C) / (4G)
    // ---------------------------------------------
    // Restoring divider, one quotient bit per cycle; saturates on overflow
    assign c_abs = (best_c_q < 0) ? -best_c_q : best_c_q;
    assign num = DW'(c_abs) << (GAIN_FRAC + 1);
    assign trial = DW'(best_g_q) << bit_q;
    assign ge = (rem_q >= trial);
    assign quo_n = quo_q | (GAIN_W'(ge) << bit_q);

    always_ff @(posedge i_core_clk) begin
        if (st_q == ST_SCAN) begin
            bit_q <= BW'(GAIN_W);
        end else if (st_q == ST_DIV) begin
            if (bit_q == BW'(GAIN_W)) begin
                rem_q <= num;
                quo_q <= '0;
                sat_q <= (best_g_q <= 0) || (num >= (DW'(best_g_q) << GAIN_W));
            end else begin
                if (ge) rem_q <= rem_q - trial; // RL10
                quo_q <= quo_n;
            end
            if (bit_q != '0) bit_q <= bit_q - 1'h1;
        end
    end

    // Answer registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            o_res_valid <= 1'h0;
            o_res <= '0;
            o_idx <= '0;
        end else begin
            o_res_valid <= div_last; // RL1
            if (div_last) begin
                o_idx <= pick_cw; // RL17
                o_res.second_cb <= cb_q;
                o_res.mode <= mode_q;
                o_res.gain <= sat_q ? '1 : quo_n; // RL10
            end
        end
    end

    // ---------------------------------------------
    // Gain quantizer selection and minimum search
    // ---------------------------------------------
    assign o_gq_sel = mode_q; // RL20
    assign o_gq_first_cb = (mode_q == MODE_TWO_CB); // RL21
    assign o_gq_ready = (st_q == ST_GQ);
    assign gq_fire = (st_q == ST_GQ) && i_gq_valid;
    assign gq_last = gq_fire && (gq_cnt_q == GQ_IDX_W'(GQ_ENTRIES - 1)); // RL23
    assign gq_lower = (gq_cnt_q == '0) || (i_gq_err < gq_min_q); // RL23

    // Strict less-than keeps the first entry on ties
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            gq_cnt_q <= '0;
            gq_best_idx_q <= '0;
            o_gq_valid <= 1'h0;
            o_gq_idx <= '0;
        end else begin
            o_gq_valid <= gq_last;
            if (gq_fire) begin
                gq_cnt_q <= gq_cnt_q + 1'h1;
                if (gq_lower) begin
                    gq_min_q <= i_gq_err;
                    gq_best_idx_q <= gq_cnt_q;
                end
                if (gq_last) o_gq_idx <= gq_lower ? gq_cnt_q : gq_best_idx_q;
            end
        end
    end

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    property p_lag_gate;
        st_q == ST_IDLE && i_start && i_mode != MODE_TWO_CB && !i_lag_valid |=> st_q == ST_IDLE;
    endproperty
    a_lag_gate: assert property (p_lag_gate) else $error("search started before lag"); // RL1
    property p_one_res;
        o_res_valid && mode_q != MODE_TWO_CB |-> !o_res.second_cb && st_q == ST_GQ;
    endproperty
    a_one_res: assert property (p_one_res) else $error("extra index in single mode"); // RL1
    property p_two_cb;
        o_res_valid && mode_q == MODE_TWO_CB && !o_res.second_cb |-> st_q == ST_LOAD && cb_q;
    endproperty
    a_two_cb: assert property (p_two_cb) else $error("second codebook not started"); // RL5
    property p_no_decor;
        st_q == ST_PREP && mode_q == MODE_TWO_CB && !cb_q |=> r_q[0] == (CW'($past(pq_q[0])) <<< 1);
    endproperty
    a_no_decor: assert property (p_no_decor) else $error("first codebook decorrelated"); // RL8
    property p_gray;
        st_q == ST_SCAN |=> $countones(cw_q ^ $past(cw_q)) == 1;
    endproperty
    a_gray: assert property (p_gray) else $error("step flipped not one bit"); // RL14
    property p_half;
        st_q == ST_SCAN |-> !cw_q[M-1];
    endproperty
    a_half: assert property (p_half) else $error("complement half visited"); // RL16
    property p_strict;
        st_q == ST_SCAN && !better |=> $stable(best_cw_q) && $stable(best_c_q);
    endproperty
    a_strict: assert property (p_strict) else $error("best replaced without gain"); // RL18
    property p_sign;
        o_res_valid |-> (o_idx == best_cw_q) == (best_c_q > 0);
    endproperty
    a_sign: assert property (p_sign) else $error("wrong sign choice"); // RL17
    property p_load_len;
        st_q == ST_PREP |-> $past(n_q) == SMP_IDX_W'(NS - 1);
    endproperty
    a_load_len: assert property (p_load_len) else $error("subframe length wrong"); // RL22
    property p_gq_cnt;
        o_gq_valid |-> $past(gq_fire) && $past(gq_cnt_q) == GQ_IDX_W'(GQ_ENTRIES - 1);
    endproperty
    a_gq_cnt: assert property (p_gq_cnt) else $error("gain search count wrong"); // RL23

    c_single: cover property (o_res_valid && mode_q != MODE_TWO_CB);
    c_second: cover property (o_res_valid && o_res.second_cb);
    c_replace: cover property (st_q == ST_SCAN && better);
    c_gq: cover property (o_gq_valid);
endmodule : cse_engine
`default_nettype wire

// [tb/cse_feeder.sv]
`default_nettype none
module cse_feeder #(
    parameter int M = 7
) (
    // Clock
    input wire logic i_core_clk,
    // Sample stream
    input wire logic i_smp_ready,
    output logic o_smp_valid,
    output logic signed [cse_pkg::SMP_W-1:0] o_basis [M],
    output cse_pkg::cse_aux_t o_aux,
    // Gain error stream
    input wire logic i_gq_ready,
    output logic o_gq_valid,
    output logic signed [cse_pkg::GQ_ERR_W-1:0] o_gq_err
);
    timeunit 1ns;
    timeprecision 100ps;
    import cse_pkg::*;

    localparam int AMP = 256;
    int cyc = 0;
    int last_cyc = 0;
    int ref_off = M + 12; // Reference sample position; a test may move it onto a basis

    // Edge count, read by the bench for latency figures
    always @(posedge i_core_clk) cyc <= cyc + 1;

    // Quiet lines at time zero
    initial begin
        o_smp_valid = 1'b0;
        o_gq_valid = 1'b0;
        o_gq_err = '0;
        o_aux = '0;
        for (int m = 0; m < M; m++) o_basis[m] = '0;
    end

    // --------------------------------------------
    // Sample pass
    // --------------------------------------------
    // Idle beats invert the lines so stale data never looks like a fresh beat
    task automatic go_idle();
        o_smp_valid = 1'b0;
        o_aux = ~o_aux;
        for (int m = 0; m < M; m++) o_basis[m] = ~o_basis[m];
    endtask : go_idle

    // Basis m is an impulse at sample off+m, so the vectors stay orthogonal
    task automatic feed_pass(input int off, input logic [M-1:0] pat, input int mag, input bit stall);
        logic took;
        for (int n = 0; n < SUBFRAME_LEN; n++) begin
            if (stall && n % 5 == 2) begin
                go_idle();
                @(posedge i_core_clk);
                #1;
            end
            o_smp_valid = 1'b1;
            for (int m = 0; m < M; m++) o_basis[m] = (n == off + m) ? 16'(AMP) : 16'h0000;
            o_aux.ref_smp = (n == off + ref_off) ? 16'h012c : 16'h0000;
            o_aux.tgt_smp = (n >= off && n < off + M) ? (pat[n - off] ? 16'(mag) : -16'(mag)) : 16'h004d;
            do begin
                took = i_smp_ready;
                @(posedge i_core_clk);
                #1;
            end while (!took);
        end
        last_cyc = cyc;
        go_idle();
    endtask : feed_pass

    // --------------------------------------------
    // Gain errors
    // --------------------------------------------
    // Last entry repeats the minimum, so a tie must keep the lower index
    task automatic feed_gq(input int best, input bit stall);
        logic took;
        for (int k = 0; k < GQ_ENTRIES; k++) begin
            if (stall && k % 7 == 3) begin
                o_gq_valid = 1'b0;
                o_gq_err = ~o_gq_err;
                @(posedge i_core_clk);
                #1;
            end
            o_gq_valid = 1'b1;
            o_gq_err = (k == GQ_ENTRIES - 1) ? -32'sd50 : 32'((k > best ? k - best : best - k) * 100 - 50);
            do begin
                took = i_gq_ready;
                @(posedge i_core_clk);
                #1;
            end while (!took);
        end
        o_gq_valid = 1'b0;
        o_gq_err = ~o_gq_err;
    endtask : feed_gq
endmodule : cse_feeder
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cse_pkg::*;

    localparam int M = NUM_BASIS;
    localparam int LAT = 2 + (2 ** (M - 1) - 1) + 17;
    logic i_core_clk = 1'b0;
    logic i_rstn, i_start, i_lag_valid, o_busy, smp_valid, o_smp_ready, o_res_valid;
    logic o_gq_first_cb, gq_valid_in, o_gq_ready, o_gq_valid;
    cse_mode_t i_mode, o_gq_sel;
    logic signed [SMP_W-1:0] basis [M];
    cse_aux_t aux;
    cse_res_t o_res;
    logic [M-1:0] o_idx;
    logic signed [GQ_ERR_W-1:0] gq_err;
    logic [GQ_IDX_W-1:0] o_gq_idx;
    logic [M-1:0] pats [4] = '{7'h2a, 7'h15, 7'h6a, 7'h7f};
    int err_count = 0;
    int compares = 0;

    // Free-running clock
    always #5 i_core_clk = ~i_core_clk;

    cse_engine #(.M(M), .NS(SUBFRAME_LEN)) cse_engine_i (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start), .i_mode(i_mode),
        .i_lag_valid(i_lag_valid), .o_busy(o_busy), .i_smp_valid(smp_valid), .o_smp_ready(o_smp_ready),
        .i_basis(basis), .i_aux(aux), .o_res_valid(o_res_valid), .o_res(o_res), .o_idx(o_idx),
        .o_gq_sel(o_gq_sel), .o_gq_first_cb(o_gq_first_cb), .i_gq_valid(gq_valid_in),
        .o_gq_ready(o_gq_ready), .i_gq_err(gq_err), .o_gq_valid(o_gq_valid), .o_gq_idx(o_gq_idx));

    cse_feeder #(.M(M)) cse_feeder_i (
        .i_core_clk(i_core_clk), .i_smp_ready(o_smp_ready), .o_smp_valid(smp_valid), .o_basis(basis),
        .o_aux(aux), .i_gq_ready(o_gq_ready), .o_gq_valid(gq_valid_in), .o_gq_err(gq_err));

    // --------------------------------------------
    // Shared tasks
    // --------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic start(input cse_mode_t mode, input logic lag);
        i_start = 1'b1;
        i_mode = mode;
        i_lag_valid = lag;
        @(posedge i_core_clk);
        #1;
        i_start = 1'b0;
        i_lag_valid = 1'b0;
    endtask : start

    // Judges one answer right after the pass that produced it
    task automatic check_answer(input cse_mode_t mode, input logic second, input logic [M-1:0] pat, input int mag);
        int t0;
        int n;
        t0 = cse_feeder_i.last_cyc;
        check("smp_ready after pass", 32'(o_smp_ready), 32'h0);
        n = 0;
        while (o_res_valid !== 1'b1 && n < 300) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        check("latency", 32'(cse_feeder_i.cyc - t0), 32'(LAT));
        check("index", 32'(o_idx), 32'(pat));
        check("gain", 32'(o_res.gain), 32'(mag * 16));
        check("second_cb", 32'(o_res.second_cb), 32'(second));
        check("mode", 32'(o_res.mode), 32'(mode));
        check("gq_sel", 32'(o_gq_sel), 32'(mode));
        check("gq_first_cb", 32'(o_gq_first_cb), 32'(mode == MODE_TWO_CB));
        @(posedge i_core_clk);
        #1;
        check("strobe width", 32'(o_res_valid), 32'h0);
    endtask : check_answer

    task automatic run_gq(input int best, input bit stall);
        int n;
        cse_feeder_i.feed_gq(best, stall);
        n = 0;
        while (o_gq_valid !== 1'b1 && n < 10) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        check("gq_idx", 32'(o_gq_idx), 32'(best));
        check("busy after gain", 32'(o_busy), 32'h0);
    endtask : run_gq

    // --------------------------------------------
    // Scenarios
    // --------------------------------------------
    task automatic t_refuse();
        start(2'h2, 1'b0);
        repeat (3) @(posedge i_core_clk);
        #1;
        check("busy without lag", 32'(o_busy), 32'h0);
        $display("test refuse done");
    endtask : t_refuse

    // Mode 2 and 3 patterns have the top bit set, so the complement path is taken
    task automatic t_single_modes();
        for (int k = 1; k < 4; k++) begin
            start(cse_mode_t'(k), 1'b1);
            check("busy after start", 32'(o_busy), 32'h1);
            cse_feeder_i.feed_pass(0, pats[k], 256 * (k + 1), 1'b0);
            check_answer(cse_mode_t'(k), 1'b0, pats[k], 256 * (k + 1));
            run_gq(k * 9, 1'b0);
        end
        $display("test single modes done");
    endtask : t_single_modes

    task automatic t_two_codebooks();
        start(MODE_TWO_CB, 1'b0);
        check("busy mode 0 start", 32'(o_busy), 32'h1);
        cse_feeder_i.feed_pass(0, 7'h4c, 512, 1'b0);
        check_answer(MODE_TWO_CB, 1'b0, 7'h4c, 512);
        cse_feeder_i.feed_pass(8, 7'h33, 768, 1'b1);
        check_answer(MODE_TWO_CB, 1'b1, 7'h33, 768);
        run_gq(0, 1'b1);
        $display("test two codebooks done");
    endtask : t_two_codebooks

    // Starts in the very cycle of the gain strobe, with stalls throughout.
    // Reference sits on basis 0, so decorrelation empties it; bit 0 then ties
    // and the earlier Gray codeword 7'h2b must win over the pattern 7'h2a
    task automatic t_back_to_back();
        start(2'h3, 1'b1);
        check("busy back to back", 32'(o_busy), 32'h1);
        cse_feeder_i.ref_off = 0;
        cse_feeder_i.feed_pass(0, pats[0], 768, 1'b1);
        check_answer(2'h3, 1'b0, 7'h2b, 768);
        run_gq(30, 1'b1);
        $display("test back to back done");
    endtask : t_back_to_back

    // Main sequence
    initial begin
        i_rstn = 1'b0;
        i_start = 1'b0;
        i_mode = '0;
        i_lag_valid = 1'b0;
        repeat (10) @(posedge i_core_clk);
        #1;
        i_rstn = 1'b1;
        check("reset first_cb", 32'(o_gq_first_cb), 32'h1);
        t_refuse();
        t_single_modes();
        t_two_codebooks();
        t_back_to_back();
        test_done();
    end

    // Watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge i_core_clk);
        err_count++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
